//--- sitx_pkg.sv
package sitx_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam logic [5:0] SITX_MODE_OFS  = 6'h00;
    localparam logic [5:0] SITX_COMM_OFS  = 6'h04;
    localparam logic [5:0] SITX_SDR_OFS   = 6'h08;
    localparam logic [5:0] SITX_LINE_OFS  = 6'h0C;
    localparam logic [5:0] SITX_OE_OFS    = 6'h10;
    localparam logic [5:0] SITX_START_OFS = 6'h14;
    localparam logic [5:0] SITX_STAT_OFS  = 6'h18;
    localparam logic [5:0] SITX_PRESC_OFS = 6'h1C;
    localparam int unsigned SITX_AW = 6;
    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned SITX_CKS_BIT    = 15;
    localparam int unsigned SITX_TXE_BIT    = 15;
    localparam int unsigned SITX_RXE_BIT    = 14;
    localparam int unsigned SITX_DIV_LSB    = 9;
    localparam int unsigned SITX_CKO_BIT    = 8;
    localparam int unsigned SITX_SO_BIT     = 0;
    localparam int unsigned SITX_OE_BIT     = 0;
    localparam int unsigned SITX_START_BIT  = 0;
    localparam int unsigned SITX_ACKERR_BIT = 0;
    localparam int unsigned SITX_BUSY_BIT   = 6;
    localparam int unsigned SITX_PSB_LSB    = 4;
    ////////////////////////////////////////////////////////////////////////////
    // widths and counts
    localparam int unsigned SITX_DIV_W  = 7;
    localparam int unsigned SITX_BYTE_W = 8;
    localparam int unsigned SITX_PS_W   = 4;
    localparam int unsigned SITX_PCNT_W = 11;
    localparam int unsigned SITX_BIT_W  = 4;
    localparam logic [3:0]  SITX_ACK_IDX = 4'h8;
    localparam logic [3:0]  SITX_PS_MAX  = 4'hB;
    ////////////////////////////////////////////////////////////////////////////
    // reset values and AXI response codes
    localparam logic [6:0]  SITX_RST_DIV  = 7'h01;
    localparam logic [7:0]  SITX_RST_DATA = 8'h00;
    localparam logic [3:0]  SITX_RST_PS   = 4'h0;
    localparam logic        SITX_RST_LVL  = 1'b1;
    localparam logic [1:0]  SITX_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SITX_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SITX_IDLE, SITX_LOW, SITX_HIGH} sitx_phase_type;
endpackage : sitx_pkg

//--- sitx_master_tx.sv
// Functional notes
// - first frame after start is 7-bit address then direction bit in LSB
// - only a transfer-end interrupt per frame; buffer-empty mode not selectable
// - only error indication is the per-channel acknowledge-error flag
// - frames carry 8 bits, MSB first, no parity
// - serial clock at most fmck/4; divider field bits 15..9 must be nonzero
// - after eight bits, one extra period releases data and samples acknowledge
// - data output non-inverted, line idles high
// - clock source select 0 picks prescaler clock A, 1 picks clock B
// - only low 8 bits of data register are the byte; upper bits divider
// - output register clock and data bits follow shifter levels during transfer
// - address then data bytes one frame each; software ends with stop
// - single master only: no slave, arbitration or clock-stretch detection
// - serial clock equals fmck divided by divider plus one, divided by two
// - serial clock high and low phases equal length
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
module sitx_master_tx (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          srst,
    // axi4-lite write channels
    input  wire logic [sitx_pkg::SITX_AW-1:0]  s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // axi4-lite read channels
    input  wire logic [sitx_pkg::SITX_AW-1:0]  s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // open-drain bus pins, oe high while pulling low
    output logic                               scl_out,
    output logic                               scl_oe,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe,
    // frame end pulse
    output logic                               transfer_end_irq
);
    import sitx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode and prescaler helpers
    function automatic logic addr_mapped(input logic [SITX_AW-1:0] a);
        addr_mapped = (a == SITX_MODE_OFS) || (a == SITX_COMM_OFS) || (a == SITX_SDR_OFS) ||
                      (a == SITX_LINE_OFS) || (a == SITX_OE_OFS) || (a == SITX_START_OFS) ||
                      (a == SITX_STAT_OFS) || (a == SITX_PRESC_OFS);
    endfunction : addr_mapped

    // tick every 2^k core cycles; k above the table maximum is clamped
    function automatic logic presc_tick(input logic [SITX_PCNT_W-1:0] cnt, input logic [SITX_PS_W-1:0] k);
        logic [SITX_PCNT_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < SITX_PCNT_W; i++) begin
            if (i < int'((k > SITX_PS_MAX) ? SITX_PS_MAX : k)) begin
                mask[i] = 1'b1;
            end
        end
        presc_tick = ((cnt & mask) == mask);
    endfunction : presc_tick

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic                   aw_held, next_aw_held, w_held, next_w_held;
    logic [SITX_AW-1:0]     wr_addr, next_wr_addr;
    logic [31:0]            wr_data, next_wr_data;
    logic [3:0]             wr_strb, next_wr_strb;
    logic                   next_bvalid, next_arready, next_rvalid;
    logic [1:0]             next_bresp, next_rresp;
    logic [31:0]            next_rdata;
    logic                   cks, next_cks, txe, next_txe, rxe, next_rxe, soe, next_soe;
    logic [SITX_DIV_W-1:0]  div, next_div;
    logic [SITX_BYTE_W-1:0] sdr_data, next_sdr_data, shreg, next_shreg;
    logic [SITX_PS_W-1:0]   ps_a, next_ps_a, ps_b, next_ps_b;
    logic [SITX_PCNT_W-1:0] pcnt, next_pcnt;
    logic [SITX_DIV_W-1:0]  half_cnt, next_half_cnt;
    logic [SITX_BIT_W-1:0]  bit_idx, next_bit_idx;
    logic                   scl_lvl, next_scl_lvl, sda_lvl, next_sda_lvl;
    logic                   sda_pending, next_sda_pending;
    logic                   ack_err, next_ack_err, next_irq;
    sitx_phase_type         state, next_state;
    logic                   wr_fire, start_go, mck_en, half_end, busy;
    logic [SITX_DIV_W-1:0]  div_eff;
    logic [31:0]            rd_word;

    // a write retires when both address and data are held and no response waits
    assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
    assign busy     = (state != SITX_IDLE);
    // a zero divider would break the fmck/4 ceiling, so it acts as one
    assign div_eff  = (div == '0) ? SITX_DIV_W'(1) : div;
    assign mck_en   = presc_tick(pcnt, cks ? ps_b : ps_a);
    assign half_end = mck_en && (half_cnt == div_eff);
    // start ignored while a frame runs: no second master or queueing exists
    assign start_go = wr_fire && (wr_addr == SITX_START_OFS) && wr_strb[0] &&
                      wr_data[SITX_START_BIT] && !busy && txe;

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave handshakes and read mux
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;
        rd_word      = 32'h0000_0000;
        unique case (s_axi_araddr)
            SITX_MODE_OFS:  rd_word[SITX_CKS_BIT] = cks;  // mode bit 0 reads 0: end-of-frame only
            SITX_COMM_OFS: begin
                rd_word[SITX_TXE_BIT] = txe;
                rd_word[SITX_RXE_BIT] = rxe;
            end
            SITX_SDR_OFS:   rd_word[15:0] = {div, 1'b0, sdr_data};
            SITX_LINE_OFS: begin
                rd_word[SITX_CKO_BIT] = scl_lvl;
                rd_word[SITX_SO_BIT]  = sda_lvl;
            end
            SITX_OE_OFS:    rd_word[SITX_OE_BIT] = soe;
            SITX_STAT_OFS: begin
                rd_word[SITX_BUSY_BIT]   = busy;
                rd_word[SITX_ACKERR_BIT] = ack_err;
            end
            SITX_PRESC_OFS: rd_word[7:0] = {ps_b, ps_a};
            default:        rd_word = 32'h0000_0000;
        endcase
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held  = 1'b1;
            next_wr_data = s_axi_wdata;
            next_wr_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = addr_mapped(wr_addr) ? SITX_RESP_OKAY : SITX_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = rd_word;
            next_rresp   = addr_mapped(s_axi_araddr) ? SITX_RESP_OKAY : SITX_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    // ready flags drop while a word is held, which gives one write in flight
    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_addr       <= '0;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= SITX_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= SITX_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            wr_addr       <= next_wr_addr;
            wr_data       <= next_wr_data;
            wr_strb       <= next_wr_strb;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready || (!next_rvalid && !s_axi_arready);
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers and the frame shifter
    always_comb begin
        next_cks         = cks;
        next_txe         = txe;
        next_rxe         = rxe;
        next_soe         = soe;
        next_div         = div;
        next_sdr_data    = sdr_data;
        next_ps_a        = ps_a;
        next_ps_b        = ps_b;
        next_pcnt        = pcnt + SITX_PCNT_W'(1);
        next_state       = state;
        next_half_cnt    = half_cnt;
        next_bit_idx     = bit_idx;
        next_shreg       = shreg;
        next_scl_lvl     = scl_lvl;
        next_sda_lvl     = sda_lvl;
        next_sda_pending = 1'b0;
        next_ack_err     = ack_err;
        next_irq         = 1'b0;
        // setting bits other than the COMM enables txe and rxe are frozen mid-frame
        if (wr_fire && !busy) begin
            unique case (wr_addr)
                SITX_MODE_OFS:  if (wr_strb[1]) next_cks = wr_data[SITX_CKS_BIT];
                SITX_SDR_OFS: begin
                    if (wr_strb[0]) next_sdr_data = wr_data[7:0];
                    if (wr_strb[1]) next_div = wr_data[15:SITX_DIV_LSB];
                end
                SITX_LINE_OFS: begin
                    if (wr_strb[1]) next_scl_lvl = wr_data[SITX_CKO_BIT];
                    if (wr_strb[0]) next_sda_lvl = wr_data[SITX_SO_BIT];
                end
                SITX_OE_OFS:    if (wr_strb[0]) next_soe = wr_data[SITX_OE_BIT];
                SITX_PRESC_OFS: if (wr_strb[0]) {next_ps_b, next_ps_a} = wr_data[7:0];
                default: ;
            endcase
        end
        if (wr_fire && (wr_addr == SITX_COMM_OFS) && wr_strb[1]) begin
            next_txe = wr_data[SITX_TXE_BIT];
            next_rxe = wr_data[SITX_RXE_BIT];
        end
        // clear by writing one; a same-cycle failing acknowledge overrides below
        if (wr_fire && (wr_addr == SITX_STAT_OFS) && wr_strb[0] && wr_data[SITX_ACKERR_BIT]) begin
            next_ack_err = 1'b0;
        end
        // data moves one core cycle after the falling clock, never at the edge
        if (sda_pending && soe) begin
            next_sda_lvl = (bit_idx == SITX_ACK_IDX) ? 1'b1 : shreg[SITX_BYTE_W-1];
        end
        unique case (state)
            SITX_IDLE: begin
                if (start_go) begin
                    next_state       = SITX_LOW;
                    next_half_cnt    = '0;
                    next_bit_idx     = '0;
                    next_shreg       = sdr_data;
                    next_scl_lvl     = 1'b0;
                    next_sda_pending = 1'b1;
                end
            end
            SITX_LOW: begin
                if (half_end) begin
                    next_half_cnt = '0;
                    next_state    = SITX_HIGH;
                    next_scl_lvl  = 1'b1;
                end else if (mck_en) begin
                    next_half_cnt = half_cnt + SITX_DIV_W'(1);
                end
            end
            SITX_HIGH: begin
                if (half_end) begin
                    next_half_cnt = '0;
                    next_scl_lvl  = 1'b0;
                    if (bit_idx == SITX_ACK_IDX) begin
                        // sample at the end of the high phase, the latest safe point
                        if (sda_in) next_ack_err = 1'b1;
                        next_irq   = 1'b1;
                        next_state = SITX_IDLE;
                    end else begin
                        next_bit_idx     = bit_idx + SITX_BIT_W'(1);
                        next_shreg       = {shreg[SITX_BYTE_W-2:0], 1'b0};
                        next_sda_pending = 1'b1;
                        next_state       = SITX_LOW;
                    end
                end else if (mck_en) begin
                    next_half_cnt = half_cnt + SITX_DIV_W'(1);
                end
            end
        endcase
    end

    // pins pulled low by enable only; level registered straight from next value
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cks              <= 1'b0;
            txe              <= 1'b0;
            rxe              <= 1'b0;
            soe              <= 1'b0;
            div              <= SITX_RST_DIV;
            sdr_data         <= SITX_RST_DATA;
            ps_a             <= SITX_RST_PS;
            ps_b             <= SITX_RST_PS;
            pcnt             <= '0;
            state            <= SITX_IDLE;
            half_cnt         <= '0;
            bit_idx          <= '0;
            shreg            <= SITX_RST_DATA;
            scl_lvl          <= SITX_RST_LVL;
            sda_lvl          <= SITX_RST_LVL;
            sda_pending      <= 1'b0;
            ack_err          <= 1'b0;
            transfer_end_irq <= 1'b0;
            scl_out          <= 1'b0;
            sda_out          <= 1'b0;
            scl_oe           <= 1'b0;
            sda_oe           <= 1'b0;
        end else begin
            cks              <= next_cks;
            txe              <= next_txe;
            rxe              <= next_rxe;
            soe              <= next_soe;
            div              <= next_div;
            sdr_data         <= next_sdr_data;
            ps_a             <= next_ps_a;
            ps_b             <= next_ps_b;
            pcnt             <= next_pcnt;
            state            <= next_state;
            half_cnt         <= next_half_cnt;
            bit_idx          <= next_bit_idx;
            shreg            <= next_shreg;
            scl_lvl          <= next_scl_lvl;
            sda_lvl          <= next_sda_lvl;
            sda_pending      <= next_sda_pending;
            ack_err          <= next_ack_err;
            transfer_end_irq <= next_irq;
            scl_out          <= 1'b0;
            sda_out          <= 1'b0;
            scl_oe           <= !next_scl_lvl;
            sda_oe           <= !next_sda_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_irq_after_ack: assert property (@(posedge core_clk) disable iff (srst)
        transfer_end_irq |-> ($past(state) == SITX_HIGH && $past(bit_idx) == SITX_ACK_IDX && !busy))
        else $error("frame end pulse without acknowledge period");
    chk_ack_error_set: assert property (@(posedge core_clk) disable iff (srst)
        (state == SITX_HIGH && half_end && bit_idx == SITX_ACK_IDX && sda_in) |=> ack_err [*2])
        else $error("acknowledge error not set or not held");
    chk_first_bit_msb: assert property (@(posedge core_clk) disable iff (srst)
        (start_go && soe) |=> ##1 (sda_lvl == $past(shreg[SITX_BYTE_W-1])))
        else $error("first bit is not the msb");
    chk_half_min_len: assert property (@(posedge core_clk) disable iff (srst)
        (busy && $changed(scl_lvl)) |=> !$changed(scl_lvl))
        else $error("clock phase shorter than two cycles");
    chk_ack_release: assert property (@(posedge core_clk) disable iff (srst)
        (state == SITX_LOW && bit_idx == SITX_ACK_IDX && soe && !sda_pending) |-> sda_lvl)
        else $error("data not released in acknowledge period");
    chk_sda_clock_low: assert property (@(posedge core_clk) disable iff (srst)
        (busy && $changed(sda_lvl)) |-> !scl_lvl)
        else $error("data changed while clock high");
    chk_pins_follow: assert property (@(posedge core_clk) disable iff (srst)
        (scl_oe == !scl_lvl) && (sda_oe == !sda_lvl))
        else $error("pin enables disagree with line levels");
    chk_phase_divider: assert property (@(posedge core_clk) disable iff (srst)
        (busy && $rose(scl_lvl)) |-> $past(half_end))
        else $error("clock rose off the divider boundary");
endmodule : sitx_master_tx

//--- sitx_slave_model.sv
module sitx_slave_model (
    // line levels and ack choice
    input  wire logic       core_clk,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    // pull and observations
    output logic            sda_pull,
    output logic [7:0]      rx_byte,
    output int              hi_len
);
    timeunit 1ns;
    timeprecision 100ps;
    int bits = 0;
    int cnt  = 0;
    initial sda_pull = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // start: data falls while clock high
    always @(negedge sda) if (scl) bits = 0;
    // sample on clock rise, msb first; a ninth rise ends the frame
    always @(posedge scl) begin
        if (bits == 9) bits = 0;
        if (bits < 8) rx_byte = {rx_byte[6:0], sda};
        bits = bits + 1;
    end
    // ack held low through bit 9, then released to the pull-up
    always @(negedge scl) sda_pull = (bits == 8) && ack_en;
    // high phase length in core cycles, kept at each fall
    always @(posedge core_clk) begin
        cnt <= scl ? cnt + 1 : 0;
        if (!scl && cnt != 0) hi_len <= cnt;
    end
endmodule : sitx_slave_model

//--- simple_i2c_master_tx_tb.sv
module simple_i2c_master_tx_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sitx_pkg::*;
    typedef struct packed {logic cks; logic [6:0] dv; logic [7:0] dat; logic ack, err; logic [7:0] hi;} sitx_row_type;
    // address frame first, then a slow clock-b byte, then a refused byte
    localparam sitx_row_type ROW_TBL [3] = '{'{1'h0, 7'h01, 8'hA4, 1'h1, 1'h0, 8'h02},
        '{1'h1, 7'h03, 8'h3C, 1'h1, 1'h0, 8'h08}, '{1'h0, 7'h01, 8'h5A, 1'h0, 1'h1, 8'h02}};
    logic        core_clk = 1'h0, srst = 1'h1, ack_en = 1'h1;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [5:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, pull, scl_drv, sda_drv;
    logic [1:0]  bresp, rresp;
    logic [7:0]  rx_byte;
    int          hi_len, num_errors = 0, n_tests = 0;
    wire         scl = !scl_oe;
    wire         sda = !(sda_oe || pull);
    ////////////////////////////////////////////////////////////////////////////
    sitx_master_tx dut_u (.core_clk, .srst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .scl_out(scl_drv), .scl_oe, .sda_in(sda), .sda_out(sda_drv), .sda_oe,
        .transfer_end_irq(irq));
    sitx_slave_model slave_u (.core_clk, .scl, .sda, .ack_en, .sda_pull(pull), .rx_byte, .hi_len);
    // free-running core clock
    always #5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // both write channels offered together, each dropped once taken
    task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
    endtask : axw
    task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : axr
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////
    // main sequence: reset, setup with software start, frame rows, ack error hold
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (8) @(posedge core_clk);
        srst <= 1'h0;
        @(posedge core_clk);
        chk("idle lines", {sda_oe, scl_oe}, 2'h0);
        axr(SITX_SDR_OFS, d, r);
        chk("sdr reset", d, 32'h0000_0200);
        axr(6'h20, d, r);
        chk("unmapped rd", r, SITX_RESP_SLVERR);
        axw(6'h24, 32'h0, r);
        chk("unmapped wr", r, SITX_RESP_SLVERR);
        axw(SITX_PRESC_OFS, 32'h0000_0010, r);
        axw(SITX_COMM_OFS, 32'h0000_8000, r);
        axw(SITX_LINE_OFS, 32'h0000_0100, r); // data low under high clock
        axw(SITX_OE_OFS, 32'h1, r);
        foreach (ROW_TBL[i]) begin
            axw(SITX_MODE_OFS, {16'h0, ROW_TBL[i].cks, 15'h0}, r); // bit 0 clear, only between frames
            axw(SITX_SDR_OFS, {16'h0, ROW_TBL[i].dv, 1'h0, ROW_TBL[i].dat}, r);
            ack_en <= ROW_TBL[i].ack;
            axw(SITX_START_OFS, 32'h1, r);
            for (int k = 0; k < 900 && irq !== 1'h1; k++) @(posedge core_clk);
            chk("frame end", irq, 1'h1);
            chk("byte", rx_byte, ROW_TBL[i].dat);
            chk("high len", hi_len, ROW_TBL[i].hi);
            axr(SITX_STAT_OFS, d, r);
            chk("ack err", d[0], ROW_TBL[i].err);
            chk("busy", d[SITX_BUSY_BIT], 1'h0);
            chk("drive lows", {scl_drv, sda_drv}, 2'h0);
            $display("row %0d done", i);
        end
        axr(SITX_STAT_OFS, d, r);
        chk("err held", d[0], 1'h1);
        axw(SITX_STAT_OFS, 32'h1, r);
        axr(SITX_STAT_OFS, d, r);
        chk("err cleared", d[0], 1'h0);
        $display("ack error hold done");
        // reset in mid-frame: lines released, frame abandoned, setup back to defaults
        axw(SITX_START_OFS, 32'h1, r);
        repeat (6) @(posedge core_clk);
        srst <= 1'h1;
        repeat (2) @(posedge core_clk);
        srst <= 1'h0;
        @(posedge core_clk);
        chk("reset lines", {sda_oe, scl_oe}, 2'h0);
        axr(SITX_SDR_OFS, d, r);
        chk("reset sdr", d, 32'h0000_0200);
        axr(SITX_STAT_OFS, d, r);
        chk("reset stat", d, 32'h0000_0000);
        $display("mid reset done");
        wrap_up();
    end
    // watchdog, well beyond the few hundred cycles the run needs
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
endmodule : simple_i2c_master_tx_tb
